// ==== rfc_map.vh ====
// constants for the rf front end control block
`ifndef RFC_MAP_VH
`define RFC_MAP_VH

// band offsets of the open loop power estimate, in dB
`define RFC_OFFSET_CELL_DB (-11'sh049)
`define RFC_OFFSET_PCS_DB (-11'sh04c)

// pcs channel at or below which the lower band select is used
`define RFC_PCS_SPLIT_CH 11'h258

// closed loop correction step and symmetric limit, in dB
`define RFC_CL_STEP_DB 11'sh001
`define RFC_CL_LIMIT_DB 11'sh03f

// output power giving zero attenuation on the gain pdm, in dBm
`define RFC_GAIN_REF_DBM 12'sh01e

// received power filter: weight of a new sample is 2^-shift
`define RFC_FILT_SHIFT 2

// clock period and timing figures
`define RFC_CLK_NS 10
`define RFC_PA_HOLD_NS 2000
`define RFC_PA_HOLD_CYC (`RFC_PA_HOLD_NS / `RFC_CLK_NS)
`define RFC_PA_DWELL_NS 20000
`define RFC_PA_DWELL_CYC (`RFC_PA_DWELL_NS / `RFC_CLK_NS)
`define RFC_SER_HALF_NS 50
`define RFC_SER_HALF_CYC (`RFC_SER_HALF_NS / `RFC_CLK_NS)

// serial word layout: read flag, seven address bits, eight data bits
`define RFC_SER_BITS 16
`define RFC_SER_DATA_BITS 8
`define RFC_SER_READ_BIT 15

// reset values of the band selects
`define RFC_RST_UPPER_BAND 1'b0
`define RFC_RST_LOWER_BAND 1'b1

`endif

// ==== rfc_pdm.v ====
// first order pulse density modulator
`timescale 1ns/1ps
module rfc_pdm #(
   parameter W = 10
) (
   input wire clk,
   input wire reset_n,
   input wire [W-1:0] level,
   output reg pdm
);
   reg [W-1:0] acc;
   wire [W:0] sum;

   // carry out of the accumulator is the density output
   assign sum = {1'b0, acc} + {1'b0, level};

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc <= {W{1'b0}};
         pdm <= 1'b0;
      end else begin
         acc <= sum[W-1:0];
         pdm <= sum[W];
      end
   end
endmodule

// ==== rfc_serial_master.v ====
// three wire serial bus master with optional readback
`timescale 1ns/1ps
`include "rfc_map.vh"
module rfc_serial_master #(
   parameter HALF = `RFC_SER_HALF_CYC,
   parameter NBITS = `RFC_SER_BITS
) (
   input wire clk,
   input wire reset_n,
   input wire start,
   input wire [NBITS-1:0] word,
   output reg busy,
   output reg done,
   output reg [`RFC_SER_DATA_BITS-1:0] rd_data,
   output reg strobe,
   output reg sclk,
   output reg data_out,
   output reg data_oe,
   input wire data_in
);
   localparam ST_IDLE = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_END = 3'b100;

   reg [2:0] state;
   reg [15:0] div;
   reg [7:0] bitcnt;
   reg [NBITS-1:0] shift;
   reg rd;
   wire div_end;

   assign div_end = (div == HALF[15:0] - 16'h0001);

   // one frame: strobe high, msb first, data changes on falling clock
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         div <= 16'h0000;
         bitcnt <= 8'h00;
         shift <= {NBITS{1'b0}};
         rd <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         rd_data <= 8'h00;
         strobe <= 1'b0;
         sclk <= 1'b0;
         data_out <= 1'b0;
         data_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start) begin
                  shift <= word;
                  rd <= word[`RFC_SER_READ_BIT];
                  data_out <= word[NBITS-1];
                  data_oe <= 1'b1;
                  strobe <= 1'b1;
                  busy <= 1'b1;
                  bitcnt <= NBITS[7:0] - 8'h01;
                  div <= 16'h0000;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               div <= div_end ? 16'h0000 : div + 16'h0001;
               if (div_end && !sclk) begin
                  sclk <= 1'b1;
                  // slave drives the data phase of a read
                  if (rd && bitcnt < `RFC_SER_DATA_BITS)
                     rd_data <= {rd_data[`RFC_SER_DATA_BITS-2:0], data_in};
               end else if (div_end) begin
                  sclk <= 1'b0;
                  if (bitcnt == 8'h00) begin
                     state <= ST_END;
                  end else begin
                     bitcnt <= bitcnt - 8'h01;
                     shift <= {shift[NBITS-2:0], 1'b0};
                     data_out <= shift[NBITS-2];
                     // release the line before the slave turns it round
                     data_oe <= !(rd && bitcnt <= `RFC_SER_DATA_BITS);
                  end
               end
            end
            ST_END: begin
               div <= div_end ? 16'h0000 : div + 16'h0001;
               if (div_end) begin
                  strobe <= 1'b0;
                  data_oe <= 1'b0;
                  data_out <= 1'b0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== rfc_frontend.v ====
// rf front end control: power loop, amplifier sequencing, pdms, buses
`timescale 1ns/1ps
`include "rfc_map.vh"
module rfc_frontend #(
   parameter PA_HOLD_CYC = `RFC_PA_HOLD_CYC,
   parameter PA_DWELL_CYC = `RFC_PA_DWELL_CYC,
   parameter SER_HALF_CYC = `RFC_SER_HALF_CYC
) (
   input wire clk,
   input wire reset_n,
   // receive strength and mode
   input wire signed [9:0] rssi_dbm,
   input wire rssi_valid,
   input wire band_is_pcs,
   input wire fm_mode,
   input wire [9:0] fm_tx_gain_code,
   input wire signed [9:0] fm_lna_rise_dbm,
   input wire signed [9:0] fm_lna_fall_dbm,
   // power loop corrections
   input wire signed [9:0] access_probe_db,
   input wire closed_loop_step,
   input wire closed_loop_up,
   input wire closed_loop_clear,
   // amplifier operating point switch levels, ascending
   input wire signed [10:0] pa_level1_dbm,
   input wire signed [10:0] pa_level2_dbm,
   input wire signed [10:0] pa_level3_dbm,
   // transmission sequencing
   input wire tx_request,
   input wire [15:0] pa_lead_cycles,
   input wire synthesizer_locked,
   input wire vco_request,
   input wire gps_acquire,
   input wire [10:0] pcs_channel,
   input wire [9:0] freq_track_level,
   // rf chip control bus
   input wire ctl_start,
   input wire [15:0] ctl_word,
   output wire ctl_busy,
   output wire ctl_done,
   output wire [7:0] ctl_read_data,
   output wire serial_ctl_strobe,
   output wire serial_ctl_clock,
   output wire serial_ctl_data_out,
   output wire serial_ctl_data_oe,
   input wire serial_ctl_data_in,
   // transmitter chip bus
   input wire tx_chip_start,
   input wire [15:0] tx_chip_word,
   output wire tx_chip_busy,
   output wire tx_chip_done,
   output wire [7:0] tx_chip_read_data,
   output wire tx_chip_serial_strobe,
   output wire tx_chip_serial_clock,
   output wire tx_chip_serial_data_out,
   output wire tx_chip_serial_data_oe,
   input wire tx_chip_serial_data_in,
   // rf control outputs
   output reg [1:0] amp_power_enable,
   output reg [1:0] amp_operating_point,
   output reg tx_keying,
   output reg upper_band_select,
   output reg lower_band_select,
   output reg vco_power_enable,
   output reg analog_mode_lna_step,
   output wire transmit_gain_pdm,
   output wire freq_track_pdm,
   output reg signed [10:0] tx_power_dbm
);
   // clamp a wide sum into the 11 bit power range
   function signed [10:0] rfc_clamp11;
      input signed [12:0] v;
      begin
         if (v > 13'sh03ff)
            rfc_clamp11 = 11'sh3ff;
         else if (v < -13'sh0400)
            rfc_clamp11 = -11'sh400;
         else
            rfc_clamp11 = v[10:0];
      end
   endfunction

   // sign extend an 11 bit value to the 13 bit working width
   function signed [12:0] rfc_ext13;
      input signed [10:0] v;
      begin
         rfc_ext13 = {{2{v[10]}}, v};
      end
   endfunction

   reg signed [12:0] filt_q;
   reg signed [10:0] cl_acc;
   reg lock_meta;
   reg lock_sync;
   reg [9:0] gain_code;
   reg [1:0] pa_cand;
   reg [15:0] dwell_cnt;
   reg pa_active;
   reg [15:0] hold_cnt;
   reg [15:0] lead_cnt;
   reg signed [10:0] next_cl;
   reg signed [11:0] atten;
   reg [1:0] pa_target;

   wire signed [12:0] rssi_q;
   wire signed [12:0] filt_err;
   wire signed [10:0] filt_db;
   wire signed [10:0] offset_db;
   wire signed [12:0] power_sum;
   wire lead_done;

   // rssi in quarter dB, one pole filter toward each new sample
   assign rssi_q = {rssi_dbm[9], rssi_dbm, 2'b00};
   assign filt_err = rssi_q - filt_q;
   assign filt_db = filt_q[12:2];

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         filt_q <= 13'sh0000;
      else if (rssi_valid)
         filt_q <= filt_q + (filt_err >>> `RFC_FILT_SHIFT);
   end

   // closed loop sum saturates so a long run of steps cannot wrap
   always @* begin
      next_cl = cl_acc;
      if (closed_loop_up && cl_acc < `RFC_CL_LIMIT_DB)
         next_cl = cl_acc + `RFC_CL_STEP_DB;
      else if (!closed_loop_up && cl_acc > -`RFC_CL_LIMIT_DB)
         next_cl = cl_acc - `RFC_CL_STEP_DB;
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         cl_acc <= 11'sh000;
      else if (closed_loop_clear)
         cl_acc <= 11'sh000;
      else if (closed_loop_step)
         cl_acc <= next_cl;
   end

   // open loop estimate plus corrections
   assign offset_db = band_is_pcs ? `RFC_OFFSET_PCS_DB :
      `RFC_OFFSET_CELL_DB;
   assign power_sum = -rfc_ext13(filt_db) + rfc_ext13(offset_db) +
      {{3{access_probe_db[9]}}, access_probe_db} + rfc_ext13(cl_acc);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         tx_power_dbm <= 11'sh000;
      else
         tx_power_dbm <= rfc_clamp11(power_sum);
   end

   // attenuation code: 16 steps per dB below the reference, clipped
   always @* begin
      atten = `RFC_GAIN_REF_DBM - {tx_power_dbm[10], tx_power_dbm};
      pa_target = 2'b00;
      if (tx_power_dbm >= pa_level1_dbm)
         pa_target = 2'b01;
      if (tx_power_dbm >= pa_level2_dbm)
         pa_target = 2'b10;
      if (tx_power_dbm >= pa_level3_dbm)
         pa_target = 2'b11;
   end

   // fm loop takes its code directly from the analog gain loop
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         gain_code <= 10'h000;
      else if (fm_mode)
         gain_code <= fm_tx_gain_code;
      else if (atten < 12'sh000)
         gain_code <= 10'h000;
      else if (atten > 12'sh03f)
         gain_code <= 10'h3ff;
      else
         gain_code <= {atten[5:0], 4'h0};
   end

   rfc_pdm #(
      .W(10)
   ) u_gain_pdm (
      .clk(clk),
      .reset_n(reset_n),
      .level(gain_code),
      .pdm(transmit_gain_pdm)
   );

   rfc_pdm #(
      .W(10)
   ) u_track_pdm (
      .clk(clk),
      .reset_n(reset_n),
      .level(freq_track_level),
      .pdm(freq_track_pdm)
   );

   // operating point moves only after the target held for the dwell;
   // this stops the amplifier chattering on a power near a level
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pa_cand <= 2'b00;
         dwell_cnt <= 16'h0000;
         amp_operating_point <= 2'b00;
      end else if (pa_target == amp_operating_point) begin
         pa_cand <= pa_target;
         dwell_cnt <= 16'h0000;
      end else if (pa_target != pa_cand) begin
         pa_cand <= pa_target;
         dwell_cnt <= 16'h0000;
      end else if (dwell_cnt >= PA_DWELL_CYC - 1) begin
         amp_operating_point <= pa_cand;
         dwell_cnt <= 16'h0000;
      end else begin
         dwell_cnt <= dwell_cnt + 16'h0001;
      end
   end

   // lock line is asynchronous to clk; second flop alone is used
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_meta <= 1'b0;
         lock_sync <= 1'b0;
      end else begin
         lock_meta <= synthesizer_locked;
         lock_sync <= lock_meta;
      end
   end

   assign lead_done = (lead_cnt >= pa_lead_cycles);

   // amplifier window opens on request, keying follows after the lead,
   // the window closes a hold time after the request drops
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pa_active <= 1'b0;
         hold_cnt <= 16'h0000;
         lead_cnt <= 16'h0000;
         tx_keying <= 1'b0;
         amp_power_enable <= 2'b00;
      end else begin
         if (tx_request) begin
            pa_active <= 1'b1;
            hold_cnt <= 16'h0000;
         end else if (pa_active) begin
            if (hold_cnt >= PA_HOLD_CYC - 1)
               pa_active <= 1'b0;
            hold_cnt <= hold_cnt + 16'h0001;
         end
         // an unlocked synthesizer restarts the lead so it is honoured
         if (tx_request && lock_sync && !lead_done)
            lead_cnt <= lead_cnt + 16'h0001;
         else if (!tx_request || !lock_sync)
            lead_cnt <= 16'h0000;
         // keying waits for an enable already standing, even with no lead
         tx_keying <= tx_request && lock_sync && lead_done &&
            (|amp_power_enable);
         if ((tx_request || pa_active) && lock_sync)
            amp_power_enable <= band_is_pcs ? 2'b10 : 2'b01;
         else
            amp_power_enable <= 2'b00;
      end
   end

   // band selects, vco and fm lna step
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_band_select <= `RFC_RST_UPPER_BAND;
         lower_band_select <= `RFC_RST_LOWER_BAND;
         vco_power_enable <= 1'b0;
         analog_mode_lna_step <= 1'b0;
      end else begin
         upper_band_select <= (pcs_channel > `RFC_PCS_SPLIT_CH);
         lower_band_select <= !(pcs_channel > `RFC_PCS_SPLIT_CH);
         vco_power_enable <= vco_request && !gps_acquire;
         // rise and fall thresholds give hysteresis on the step
         if (!fm_mode)
            analog_mode_lna_step <= 1'b0;
         else if (rssi_valid && rssi_dbm > fm_lna_rise_dbm)
            analog_mode_lna_step <= 1'b1;
         else if (rssi_valid && rssi_dbm < fm_lna_fall_dbm)
            analog_mode_lna_step <= 1'b0;
      end
   end

   // general rf chip bus, with readback
   rfc_serial_master #(
      .HALF(SER_HALF_CYC),
      .NBITS(`RFC_SER_BITS)
   ) u_ctl_bus (
      .clk(clk),
      .reset_n(reset_n),
      .start(ctl_start),
      .word(ctl_word),
      .busy(ctl_busy),
      .done(ctl_done),
      .rd_data(ctl_read_data),
      .strobe(serial_ctl_strobe),
      .sclk(serial_ctl_clock),
      .data_out(serial_ctl_data_out),
      .data_oe(serial_ctl_data_oe),
      .data_in(serial_ctl_data_in)
   );

   // separate bus for the transmitter chip
   rfc_serial_master #(
      .HALF(SER_HALF_CYC),
      .NBITS(`RFC_SER_BITS)
   ) u_tx_chip_bus (
      .clk(clk),
      .reset_n(reset_n),
      .start(tx_chip_start),
      .word(tx_chip_word),
      .busy(tx_chip_busy),
      .done(tx_chip_done),
      .rd_data(tx_chip_read_data),
      .strobe(tx_chip_serial_strobe),
      .sclk(tx_chip_serial_clock),
      .data_out(tx_chip_serial_data_out),
      .data_oe(tx_chip_serial_data_oe),
      .data_in(tx_chip_serial_data_in)
   );
endmodule

// ==== rfc_chip_model.sv ====
// serial slave model of an rf chip on a three wire control bus
`timescale 1ns/1ps
module rfc_chip_model #(
   parameter [7:0] RD_VALUE = 8'h5a
) (
   input wire clk,
   input wire strobe,
   input wire sclk,
   input wire data_out,
   input wire data_oe,
   output wire line,
   output reg [15:0] last_word
);
   reg sclk_q = 1'b0;
   reg drv = 1'b0;
   reg bit_o = 1'b0;
   reg tog = 1'b0;
   reg [4:0] cnt = 5'h00;
   reg [15:0] word = 16'h0000;
   // released line toggles so a stale bit never reads as valid
   assign line = data_oe ? data_out : (drv ? bit_o : tog);
   // shift in on rising serial clock, answer reads on falling clock
   always @(posedge clk) begin
      sclk_q <= sclk;
      tog <= ~tog;
      if (!strobe) begin
         drv <= 1'b0;
         cnt <= 5'h00;
      end else if (sclk && !sclk_q) begin
         word <= {word[14:0], line};
         last_word <= {word[14:0], line};
         cnt <= cnt + 5'h01;
      end else if (!sclk && sclk_q && cnt >= 5'h08 && cnt < 5'h10) begin
         drv <= (cnt == 5'h08) ? word[7] : drv;
         bit_o <= RD_VALUE[5'h0f - cnt];
      end
   end
endmodule

// ==== rfc_frontend_asserts.sv ====
// checker of the rf front end control outputs
`timescale 1ns/1ps
module rfc_frontend_chk (
   input wire clk,
   input wire reset_n,
   input wire band_is_pcs,
   input wire [10:0] pcs_channel,
   input wire vco_request,
   input wire gps_acquire,
   input wire synthesizer_locked,
   input wire tx_request,
   input wire fm_mode,
   input wire ctl_busy,
   input wire ctl_done,
   input wire serial_ctl_strobe,
   input wire serial_ctl_clock,
   input wire tx_chip_busy,
   input wire tx_chip_done,
   input wire tx_chip_serial_strobe,
   input wire tx_chip_serial_clock,
   input wire [1:0] amp_power_enable,
   input wire tx_keying,
   input wire upper_band_select,
   input wire lower_band_select,
   input wire vco_power_enable,
   input wire analog_mode_lna_step
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // band and oscillator controls
   band_cmpl_a: assert property (
      upper_band_select != lower_band_select)
      else $error("band selects not complementary");
   band_split_a: assert property ($past(band_is_pcs) |->
      upper_band_select == ($past(pcs_channel) > 11'h258))
      else $error("band select wrong for channel");
   vco_gps_a: assert property (
      vco_power_enable == $past(vco_request && !gps_acquire))
      else $error("vco enable wrong");
   // amplifier sequencing and fm lna step
   lock_gate_a: assert property (!synthesizer_locked [*3] |=>
      amp_power_enable == 2'b00 && !tx_keying)
      else $error("amplifier on without lock");
   pa_band_a: assert property ($rose(|amp_power_enable) |->
      amp_power_enable == {band_is_pcs, !band_is_pcs})
      else $error("amplifier enable on wrong band");
   key_in_pa_a: assert property (tx_keying |-> |amp_power_enable)
      else $error("keying outside amplifier enable");
   key_lead_a: assert property ($rose(tx_keying) |->
      $past(|amp_power_enable))
      else $error("keying without lead");
   key_off_a: assert property (!tx_request |=> !tx_keying)
      else $error("keying stays on");
   lna_fm_a: assert property (!fm_mode |=> !analog_mode_lna_step)
      else $error("lna step outside fm");
   // serial buses
   ser_start_a: assert property ($rose(serial_ctl_strobe) |->
      ctl_busy && !serial_ctl_clock)
      else $error("frame start wrong");
   ser_done_a: assert property (ctl_done |-> $past(ctl_busy) &&
      !ctl_busy && !serial_ctl_strobe && !serial_ctl_clock)
      else $error("frame end wrong");
   tx_ser_done_a: assert property (tx_chip_done |->
      $past(tx_chip_busy) && !tx_chip_serial_strobe && !tx_chip_serial_clock)
      else $error("tx chip frame end wrong");
endmodule
bind rfc_frontend rfc_frontend_chk chk_i (.*);

// ==== rfc_frontend_tb.sv ====
// self-checking bench of the rf front end control block
`timescale 1ns/1ps
module rfc_frontend_tb;
   localparam HOLD = 40;
   localparam DWELL = 4;
   localparam [7:0] RD0 = 8'h5a;
   localparam [7:0] RD1 = 8'hc3;
   localparam int LR[5] = '{-40, -60, -80, -60, -40};
   localparam [4:0] LE = 5'b10011;
   localparam int PT[5] = '{-30, 0, 20, 19, -20};
   logic clk = 1'b0;
   logic reset_n;
   logic signed [9:0] rssi_dbm, fm_lna_rise_dbm, fm_lna_fall_dbm;
   logic signed [9:0] access_probe_db;
   logic signed [10:0] pa_level1_dbm, pa_level2_dbm, pa_level3_dbm;
   logic signed [10:0] tx_power_dbm;
   logic [9:0] fm_tx_gain_code, freq_track_level;
   logic [15:0] pa_lead_cycles, ctl_word, tx_chip_word, lw0, lw1;
   logic [10:0] pcs_channel;
   logic [7:0] ctl_read_data, tx_chip_read_data;
   logic [1:0] amp_power_enable, amp_operating_point;
   logic rssi_valid, band_is_pcs, fm_mode, closed_loop_step, closed_loop_up;
   logic closed_loop_clear, tx_request, synthesizer_locked, vco_request;
   logic gps_acquire, ctl_start, tx_chip_start, ctl_busy, ctl_done;
   logic serial_ctl_strobe, serial_ctl_clock, serial_ctl_data_out;
   logic serial_ctl_data_oe, serial_ctl_data_in, tx_chip_busy, tx_chip_done;
   logic tx_chip_serial_strobe, tx_chip_serial_clock, tx_chip_serial_data_out;
   logic tx_chip_serial_data_oe, tx_chip_serial_data_in, tx_keying;
   logic upper_band_select, lower_band_select, vco_power_enable;
   logic analog_mode_lna_step, transmit_gain_pdm, freq_track_pdm;
   int errors = 0, checked = 0, filt = 0, cl = 0, k, c;
   logic [31:0] seed = 32'hbc73_963c;
   // short counts keep the run brief
   rfc_frontend #(.PA_HOLD_CYC(HOLD), .PA_DWELL_CYC(DWELL),
      .SER_HALF_CYC(2)) DUT (.*);
   // one chip model on each serial bus
   rfc_chip_model #(.RD_VALUE(RD0)) chip0 (.clk(clk),
      .strobe(serial_ctl_strobe), .sclk(serial_ctl_clock),
      .data_out(serial_ctl_data_out), .data_oe(serial_ctl_data_oe),
      .line(serial_ctl_data_in), .last_word(lw0));
   rfc_chip_model #(.RD_VALUE(RD1)) chip1 (.clk(clk),
      .strobe(tx_chip_serial_strobe), .sclk(tx_chip_serial_clock),
      .data_out(tx_chip_serial_data_out), .data_oe(tx_chip_serial_data_oe),
      .line(tx_chip_serial_data_in), .last_word(lw1));
   always #5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // checks land one step after the edge, once outputs settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return |amp_power_enable;
         1: return tx_keying;
         2: return ctl_done;
         default: return tx_chip_done;
      endcase
   endfunction
   // bounded wait; k holds the cycles taken
   task automatic wt(input int s, input logic v, input int n);
      #1;
      for (k = 0; k < n && sig(s) !== v; k++)
         cyc(1);
      if (sig(s) !== v) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic rs(input int r);
      @(posedge clk);
      rssi_dbm <= 10'(r);
      rssi_valid <= 1'b1;
      @(posedge clk);
      rssi_valid <= 1'b0;
      filt += (r * 4 - filt) >>> 2;
   endtask
   function automatic int pw();
      return -(filt >>> 2) + (band_is_pcs ? -76 : -73) + access_probe_db + cl;
   endfunction
   function automatic int gc(input int p);
      return 30 - p < 0 ? 0 : (30 - p > 63 ? 1023 : (30 - p) * 16);
   endfunction
   task automatic st(input logic up);
      @(posedge clk);
      closed_loop_step <= 1'b1;
      closed_loop_up <= up;
      @(posedge clk);
      closed_loop_step <= 1'b0;
      cl = up ? (cl < 63 ? cl + 1 : 63) : (cl > -63 ? cl - 1 : -63);
   endtask
   task automatic pd(input int g, input int f);
      int a = 0;
      int b = 0;
      repeat (1024) begin
         cyc(1);
         a += transmit_gain_pdm;
         b += freq_track_pdm;
      end
      chk(a >= g - 2 && a <= g + 2, 1);
      chk(b >= f - 2 && b <= f + 2, 1);
   endtask
   // one frame on bus b, then the word the chip saw and any read byte
   task automatic sx(input int b, input logic [15:0] w);
      @(posedge clk);
      if (b) begin
         tx_chip_start <= 1'b1;
         tx_chip_word <= w;
      end else begin
         ctl_start <= 1'b1;
         ctl_word <= w;
      end
      @(posedge clk);
      {ctl_start, tx_chip_start} <= 2'b00;
      wt(2 + b, 1'b1, 400);
      cyc(2);
      chk(b ? lw1 : lw0, w[15] ? {w[15:8], b ? RD1 : RD0} : w);
      if (w[15])
         chk(b ? tx_chip_read_data : ctl_read_data, b ? RD1 : RD0);
   endtask
   initial begin
      {rssi_dbm, rssi_valid, band_is_pcs, fm_mode, fm_tx_gain_code,
         access_probe_db, closed_loop_step, closed_loop_up, closed_loop_clear,
         tx_request, vco_request, gps_acquire, pcs_channel, freq_track_level,
         ctl_start, ctl_word, tx_chip_start, tx_chip_word} = 0;
      fm_lna_rise_dbm = -10'sd50;
      fm_lna_fall_dbm = -10'sd70;
      pa_level1_dbm = -11'sd20;
      pa_level2_dbm = 11'sd0;
      pa_level3_dbm = 11'sd20;
      pa_lead_cycles = 16'h0008;
      synthesizer_locked = 1'b1;
      reset_n = 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      cyc(1);
      chk({amp_power_enable, tx_keying, lower_band_select}, 4'b0001);
      // band split corners and random channels, vco with gps
      for (int i = 0; i < 8; i++) begin
         c = i == 0 ? 600 : i == 1 ? 601 : i == 2 ? 2047 : rnd() % 2048;
         @(posedge clk);
         pcs_channel <= 11'(c);
         band_is_pcs <= 1'b1;
         vco_request <= c[3];
         gps_acquire <= i[0];
         cyc(2);
         chk({upper_band_select, lower_band_select}, 1 + (c > 600));
         chk(vco_power_enable, vco_request & !gps_acquire);
      end
      // power loop with random rssi, probe and loop steps
      for (int i = 0; i < 6; i++) begin
         c = rnd();
         @(posedge clk);
         band_is_pcs <= c[0];
         access_probe_db <= $signed(c[13:9]);
         rs(-(c[20:15]) - 40);
         st(c[21]);
         st(c[22]);
         cyc(3);
         chk(tx_power_dbm, 11'(pw()));
      end
      repeat (70) st(1'b1);
      cyc(3);
      chk(tx_power_dbm, 11'(pw()));
      @(posedge clk);
      closed_loop_clear <= 1'b1;
      @(posedge clk);
      closed_loop_clear <= 1'b0;
      cl = 0;
      cyc(3);
      chk(tx_power_dbm, 11'(pw()));
      // pdm densities in cdma then fm
      @(posedge clk);
      freq_track_level <= c[9:0];
      access_probe_db <= 10'(access_probe_db + 10 - pw());
      cyc(4);
      pd(gc(pw()), c[9:0]);
      @(posedge clk);
      fm_mode <= 1'b1;
      fm_tx_gain_code <= c[19:10];
      cyc(4);
      pd(c[19:10], c[9:0]);
      // lna step thresholds with hysteresis band
      for (int i = 0; i < 5; i++) begin
         rs(LR[i]);
         cyc(2);
         chk(analog_mode_lna_step, LE[i]);
      end
      @(posedge clk);
      fm_mode <= 1'b0;
      cyc(3);
      chk(analog_mode_lna_step, 0);
      // operating point levels, boundaries and a short glitch
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         access_probe_db <= 10'(access_probe_db + PT[i] - pw());
         cyc(DWELL + 8);
         chk(amp_operating_point, (PT[i] >= -20) + (PT[i] >= 0)
            + (PT[i] >= 20));
      end
      c = access_probe_db;
      @(posedge clk);
      access_probe_db <= 10'(c + 45);
      @(posedge clk);
      access_probe_db <= 10'(c);
      cyc(DWELL + 8);
      chk(amp_operating_point, 1);
      // amplifier lead, keying, hold and lock loss on both bands
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         band_is_pcs <= b[0];
         pa_lead_cycles <= 16'(8 + 6 * b);
         tx_request <= 1'b1;
         wt(0, 1'b1, 20);
         chk(amp_power_enable, b ? 2'b10 : 2'b01);
         wt(1, 1'b1, 40);
         chk(k >= 6 + 6 * b && k <= 10 + 6 * b, 1);
         @(posedge clk);
         tx_request <= 1'b0;
         cyc(1);
         chk(tx_keying, 0);
         wt(0, 1'b0, HOLD + 20);
         chk(k >= HOLD - 4 && k <= HOLD + 4, 1);
         @(posedge clk);
         tx_request <= 1'b1;
         wt(1, 1'b1, 40);
         @(posedge clk);
         synthesizer_locked <= 1'b0;
         cyc(1);
         chk(|amp_power_enable, 1);
         cyc(3);
         chk({amp_power_enable, tx_keying}, 0);
         cyc(20);
         chk(amp_power_enable, 0);
         @(posedge clk);
         synthesizer_locked <= 1'b1;
         wt(1, 1'b1, 50);
         @(posedge clk);
         tx_request <= 1'b0;
         wt(0, 1'b0, HOLD + 20);
      end
      // writes and reads on both serial buses
      for (int i = 0; i < 4; i++) begin
         c = rnd();
         sx(i % 2, {i[1], c[14:0]});
      end
      finish_test();
   end
endmodule
